/* ftc_pkg.sv */
// Package: register map, field layout, reset values and timing for the transaction config block
package ftc_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_CFG3_NV = 8'h00;
    localparam logic [7:0] OFS_CFG3_V = 8'h04;
    localparam logic [7:0] OFS_CFG4_NV = 8'h08;
    localparam logic [7:0] OFS_CFG4_V = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // Transaction config fields
    localparam int LAT_LSB = 6;
    localparam int BLANK_BIT = 5;
    localparam int PBUF_BIT = 4;
    localparam int SMAP_BIT = 3;
    // Burst, ECC and drive config fields
    localparam int DRV_LSB = 5;
    localparam int WRAP_EN_BIT = 4;
    localparam int ECC_BIT = 3;
    localparam int SLEEP_BIT = 2;
    localparam int WRAP_LEN_LSB = 0;
    // Reset values
    localparam logic [7:0] CFG3_RESET = 8'h00;
    localparam logic [7:0] CFG4_RESET = 8'ha8;
    // Fixed latencies and dummy-cycle offsets
    localparam logic [5:0] UID_LATENCY = 6'h20;
    localparam logic [5:0] CRC_LATENCY = 6'h08;
    localparam logic [5:0] OCTAL_LAT_BASE = 6'h03;
    // Program buffer sizes minus one
    localparam logic [8:0] PBUF_LAST_SMALL = 9'h0ff;
    localparam logic [8:0] PBUF_LAST_LARGE = 9'h1ff;
    // Drive codes that alias each other
    localparam logic [2:0] DRV_ALIAS = 3'h4;
    localparam logic [2:0] DRV_CANON = 3'h0;
    // Read transaction kinds for latency lookup
    typedef enum logic [2:0] {
        KIND_ANY_REG,
        KIND_DYN_PROT,
        KIND_STATUS_ID,
        KIND_UNIQUE_ID,
        KIND_CRC_VALUE
    } ftc_kind_type;
    // Power state
    typedef enum logic [1:0] {
        PWR_LOAD,
        PWR_STANDBY,
        PWR_DEEP_SLEEP
    } ftc_pwr_type;
endpackage

/* ftc_config_regs.sv */
// Transaction, burst-wrap, ECC and drive configuration registers with APB access
//
// Overview of operation
// - Two-bit latency code, reset zero, picks dummy cycles for register reads.
// - Octal mode: codes 00..11 give 3, 4, 5, 6 dummy cycles.
// - Single-bit: 0,1,1,2 for any/dynamic reads; 0,0,1,2 for status/id/lock.
// - Unique-identifier read always uses 32 latency cycles.
// - CRC-value read always uses 8 latency cycles.
// - Blank check on: erase of an already blank sector is aborted, except a small-sector erase ignored under the uniform map.
// - Blank check off: every erase runs, except a small-sector erase ignored under the uniform map.
// - Buffer size bit: 0 gives 256 bytes, 1 gives 512 bytes.
// - Program data beyond the buffer size wraps within the buffer.
// - Map bit 0 is hybrid with 4KB sectors; 1 is uniform without them.
// - Hybrid map places the 4KB block at the top or bottom range.
// - Small-sector erase is accepted only with hybrid map, else ignored.
// - Three-bit drive field, reset 101; codes 000 and 100 are the same.
// - Wrap enable: 1 wraps main-array reads, 0 reads sequentially.
// - Wrap length codes 00..11 give 8, 16, 32, 64 byte groups.
// - Wrapped read address increments within the aligned group and loops.
// - ECC bit, reset 1: 0 single correction only, 1 adds double detection.
// - Sleep bit 1 enters deep power-down after power-on, else standby; the load state only ever sees the nonvolatile reset value 0, so standby.
// - Chip-select pulse or hardware reset leaves deep power-down.
`timescale 1ns/1ps
module ftc_config_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link pins from the host
    input wire logic link_clk,
    input wire logic link_cs_n,
    input wire logic hw_reset_n,
    // Register read latency request
    input wire logic lat_start,
    input wire logic [2:0] lat_kind,
    input wire logic octal_mode,
    output logic [5:0] dummy_cycles,
    output logic lat_done,
    // Erase request
    input wire logic erase_req,
    input wire logic erase_small,
    input wire logic sector_blank,
    output logic erase_start,
    output logic erase_abort,
    output logic erase_ignored,
    // Program buffer fill
    input wire logic prog_begin,
    input wire logic prog_byte,
    output logic [8:0] prog_index,
    // Main array burst read
    input wire logic read_begin,
    input wire logic [7:0] read_addr_start,
    input wire logic read_byte,
    output logic [7:0] read_addr,
    // Static configuration outputs
    output logic small_sectors_mapped,
    output logic [2:0] drive_setting,
    output logic ecc_double_detect,
    output logic deep_sleep_state
);
    // Register storage and control state
    logic [7:0] cfg3_nv_reg;
    logic [7:0] cfg3_v_reg;
    logic [7:0] cfg4_nv_reg;
    logic [7:0] cfg4_v_reg;
    ftc_pkg::ftc_pwr_type pwr_reg;
    logic [5:0] lat_count_reg;
    logic lat_busy_reg;
    logic [2:0] cs_sync_reg;
    logic [1:0] hw_sync_reg;
    logic hw_prev_reg;
    logic [2:0] lclk_sync_reg;

    // Field views of the volatile copies, which govern behaviour
    wire [1:0] lat_code = cfg3_v_reg[ftc_pkg::LAT_LSB +: 2];
    wire blank_en = cfg3_v_reg[ftc_pkg::BLANK_BIT];
    wire pbuf_large = cfg3_v_reg[ftc_pkg::PBUF_BIT];
    wire uniform_map = cfg3_v_reg[ftc_pkg::SMAP_BIT];
    wire [2:0] drv_code = cfg4_v_reg[ftc_pkg::DRV_LSB +: 3];
    wire wrap_en = cfg4_v_reg[ftc_pkg::WRAP_EN_BIT];
    wire [1:0] wrap_len = cfg4_v_reg[ftc_pkg::WRAP_LEN_LSB +: 2];

    // APB decode; one wait state, transfer completes on the pready edge
    wire apb_done = psel && penable && pready;
    wire apb_wr = apb_done && pwrite;
    wire hit3n = (paddr == ftc_pkg::OFS_CFG3_NV);
    wire hit3v = (paddr == ftc_pkg::OFS_CFG3_V);
    wire hit4n = (paddr == ftc_pkg::OFS_CFG4_NV);
    wire hit4v = (paddr == ftc_pkg::OFS_CFG4_V);
    wire hitst = (paddr == ftc_pkg::OFS_STATUS);
    wire mapped = hit3n || hit3v || hit4n || hit4v || hitst;
    wire [31:0] status_word = {29'h0, ecc_double_detect, lat_busy_reg,
        (pwr_reg == ftc_pkg::PWR_DEEP_SLEEP)};
    wire [31:0] rd_mux = hit3n ? {24'h0, cfg3_nv_reg} :
        hit3v ? {24'h0, cfg3_v_reg} :
        hit4n ? {24'h0, cfg4_nv_reg} :
        hit4v ? {24'h0, cfg4_v_reg} :
        hitst ? status_word : 32'h0;

    // Volatile write masks: map and sleep bits are read-only in the volatile copy
    wire [7:0] v3_wmask = ~(8'h01 << ftc_pkg::SMAP_BIT);
    wire [7:0] v4_wmask = ~(8'h01 << ftc_pkg::SLEEP_BIT);

    // Link pin events after two-flop synchronisers
    wire cs_pulse = cs_sync_reg[2] && !cs_sync_reg[1] ? 1'b0 :
        (!cs_sync_reg[2] && cs_sync_reg[1]);
    wire hw_reset_evt = hw_prev_reg && !hw_sync_reg[1];
    wire lclk_rise = !lclk_sync_reg[2] && lclk_sync_reg[1];

    // Dummy-cycle lookup from the volatile latency code
    logic [5:0] lat_lookup;
    always_comb begin
        case (ftc_pkg::ftc_kind_type'(lat_kind))
            ftc_pkg::KIND_UNIQUE_ID: lat_lookup = ftc_pkg::UID_LATENCY;
            ftc_pkg::KIND_CRC_VALUE: lat_lookup = ftc_pkg::CRC_LATENCY;
            default: begin
                if (octal_mode) begin
                    lat_lookup = ftc_pkg::OCTAL_LAT_BASE + {4'h0, lat_code};
                end else if (lat_kind == ftc_pkg::KIND_STATUS_ID) begin
                    lat_lookup = {5'h0, lat_code[1]} +
                        {5'h0, lat_code[1] & lat_code[0]};
                end else begin
                    lat_lookup = {5'h0, |lat_code} + {5'h0, &lat_code};
                end
            end
        endcase
    end

    // Erase decisions
    wire small_ok = !erase_small || !uniform_map;
    wire erase_go = erase_req && small_ok && !(blank_en && sector_blank);
    wire erase_stop = erase_req && small_ok && blank_en && sector_blank;

    // Program buffer index wraps at the selected size
    wire [8:0] pbuf_last = pbuf_large ? ftc_pkg::PBUF_LAST_LARGE :
        ftc_pkg::PBUF_LAST_SMALL;
    wire [8:0] pidx_inc = (prog_index + 9'h001) & pbuf_last;

    // Burst address step, aligned group mask from the wrap length
    wire [7:0] wrap_mask = (8'h08 << wrap_len) - 8'h01;
    wire [7:0] addr_inc = read_addr + 8'h01;
    wire [7:0] addr_step = wrap_en ? ((read_addr & ~wrap_mask) | (addr_inc & wrap_mask)) :
        addr_inc;

    // APB response; unmapped addresses answer with an error and zero data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready) ? rd_mux : prdata;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    // Nonvolatile copies: written only by software; reserved bits kept as written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg3_nv_reg <= ftc_pkg::CFG3_RESET;
            cfg4_nv_reg <= ftc_pkg::CFG4_RESET;
        end else begin
            if (apb_wr && hit3n) begin
                cfg3_nv_reg <= pwdata[7:0];
            end
            if (apb_wr && hit4n) begin
                cfg4_nv_reg <= pwdata[7:0];
            end
        end
    end

    // Volatile copies: reloaded from nonvolatile on power-on and hardware reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg3_v_reg <= ftc_pkg::CFG3_RESET;
            cfg4_v_reg <= ftc_pkg::CFG4_RESET;
        end else if (pwr_reg == ftc_pkg::PWR_LOAD || hw_reset_evt) begin
            cfg3_v_reg <= cfg3_nv_reg;
            cfg4_v_reg <= cfg4_nv_reg;
        end else begin
            if (apb_wr && hit3v) begin
                cfg3_v_reg <= (pwdata[7:0] & v3_wmask) | (cfg3_v_reg & ~v3_wmask);
            end
            if (apb_wr && hit4v) begin
                cfg4_v_reg <= (pwdata[7:0] & v4_wmask) | (cfg4_v_reg & ~v4_wmask);
            end
        end
    end

    // Synchronisers for chip select, hardware reset and link clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_sync_reg <= 3'h7;
            hw_sync_reg <= 2'h3;
            hw_prev_reg <= 1'b1;
            lclk_sync_reg <= 3'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], link_cs_n};
            hw_sync_reg <= {hw_sync_reg[0], hw_reset_n};
            hw_prev_reg <= hw_sync_reg[1];
            lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk};
        end
    end

    // Power state; the load state runs once after reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_reg <= ftc_pkg::PWR_LOAD;
        end else begin
            case (pwr_reg)
                ftc_pkg::PWR_LOAD: begin
                    pwr_reg <= cfg4_nv_reg[ftc_pkg::SLEEP_BIT] ?
                        ftc_pkg::PWR_DEEP_SLEEP : ftc_pkg::PWR_STANDBY;
                end
                ftc_pkg::PWR_DEEP_SLEEP: begin
                    if (cs_pulse || hw_reset_evt) begin
                        pwr_reg <= ftc_pkg::PWR_STANDBY;
                    end
                end
                default: begin
                    pwr_reg <= ftc_pkg::PWR_STANDBY;
                end
            endcase
        end
    end

    // Dummy-cycle counter paced by link clock rising edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dummy_cycles <= 6'h0;
            lat_count_reg <= 6'h0;
            lat_busy_reg <= 1'b0;
            lat_done <= 1'b0;
        end else if (lat_start) begin
            dummy_cycles <= lat_lookup;
            lat_count_reg <= lat_lookup;
            lat_busy_reg <= 1'b1;
            lat_done <= 1'b0;
        end else begin
            lat_done <= lat_busy_reg && (lat_count_reg == 6'h0);
            lat_busy_reg <= lat_busy_reg && (lat_count_reg != 6'h0);
            if (lat_busy_reg && lclk_rise && lat_count_reg != 6'h0) begin
                lat_count_reg <= lat_count_reg - 6'h01;
            end
        end
    end

    // Erase strobes, one cycle each
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            erase_start <= 1'b0;
            erase_abort <= 1'b0;
            erase_ignored <= 1'b0;
        end else begin
            erase_start <= erase_go;
            erase_abort <= erase_stop;
            erase_ignored <= erase_req && !small_ok;
        end
    end

    // Program index and burst read address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_index <= 9'h0;
            read_addr <= 8'h0;
        end else begin
            if (prog_begin) begin
                prog_index <= 9'h0;
            end else if (prog_byte) begin
                prog_index <= pidx_inc;
            end
            if (read_begin) begin
                read_addr <= read_addr_start;
            end else if (read_byte) begin
                read_addr <= addr_step;
            end
        end
    end

    // Static outputs; 4KB block placement itself belongs to the sector decoder
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            small_sectors_mapped <= 1'b0;
            drive_setting <= 3'h0;
            ecc_double_detect <= 1'b0;
            deep_sleep_state <= 1'b0;
        end else begin
            small_sectors_mapped <= !uniform_map;
            drive_setting <= (drv_code == ftc_pkg::DRV_ALIAS) ? ftc_pkg::DRV_CANON :
                drv_code;
            ecc_double_detect <= cfg4_v_reg[ftc_pkg::ECC_BIT];
            deep_sleep_state <= (pwr_reg == ftc_pkg::PWR_DEEP_SLEEP);
        end
    end

    // Checks on the block's own behaviour
    property p_octal_lat;
        @(posedge clk) disable iff (!arst_n)
        lat_start && octal_mode && lat_kind == 3'h0 |=>
            dummy_cycles == 6'h03 + {4'h0, $past(lat_code)};
    endproperty
    a_octal_lat: assert property (p_octal_lat) else $error("octal latency wrong");
    property p_uid_lat;
        @(posedge clk) disable iff (!arst_n)
        lat_start && lat_kind == 3'h3 |=> dummy_cycles == 6'h20;
    endproperty
    a_uid_lat: assert property (p_uid_lat) else $error("unique id latency wrong");
    property p_crc_lat;
        @(posedge clk) disable iff (!arst_n)
        lat_start && lat_kind == 3'h4 |=> dummy_cycles == 6'h08;
    endproperty
    a_crc_lat: assert property (p_crc_lat) else $error("crc latency wrong");
    property p_single_status;
        @(posedge clk) disable iff (!arst_n)
        lat_start && !octal_mode && lat_kind == 3'h2 && lat_code == 2'h2 |=>
            dummy_cycles == 6'h01;
    endproperty
    a_single_status: assert property (p_single_status) else $error("status latency wrong");
    property p_blank_abort;
        @(posedge clk) disable iff (!arst_n)
        erase_req && blank_en && sector_blank && !erase_small |=> erase_abort && !erase_start;
    endproperty
    a_blank_abort: assert property (p_blank_abort) else $error("blank erase not aborted");
    property p_no_check;
        @(posedge clk) disable iff (!arst_n)
        erase_req && !blank_en && !erase_small |=> erase_start;
    endproperty
    a_no_check: assert property (p_no_check) else $error("erase not started");
    property p_small_ignored;
        @(posedge clk) disable iff (!arst_n)
        erase_req && erase_small && uniform_map |=> erase_ignored && !erase_start && !erase_abort;
    endproperty
    a_small_ignored: assert property (p_small_ignored) else $error("small erase accepted");
    property p_pbuf_wrap;
        @(posedge clk) disable iff (!arst_n)
        prog_byte && !prog_begin && !pbuf_large && prog_index == 9'h0ff |=> prog_index == 9'h0;
    endproperty
    a_pbuf_wrap: assert property (p_pbuf_wrap) else $error("buffer did not wrap");
    property p_wrap8;
        @(posedge clk) disable iff (!arst_n)
        read_byte && !read_begin && wrap_en && wrap_len == 2'h0 && read_addr[2:0] == 3'h7 |=>
            read_addr == {$past(read_addr[7:3]), 3'h0};
    endproperty
    a_wrap8: assert property (p_wrap8) else $error("8-byte wrap wrong");
    property p_drive_alias;
        @(posedge clk) disable iff (!arst_n)
        drv_code == 3'h4 |=> drive_setting == 3'h0;
    endproperty
    a_drive_alias: assert property (p_drive_alias) else $error("drive alias wrong");
    property p_wake;
        @(posedge clk) disable iff (!arst_n)
        pwr_reg == ftc_pkg::PWR_DEEP_SLEEP && cs_pulse |=> ##1 !deep_sleep_state;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake from deep sleep");
    property p_load;
        @(posedge clk) disable iff (!arst_n)
        hw_reset_evt |=> cfg3_v_reg == $past(cfg3_nv_reg) && cfg4_v_reg == $past(cfg4_nv_reg);
    endproperty
    a_load: assert property (p_load) else $error("volatile copy not reloaded");
endmodule

/* ftc_host_model.sv */
// Host controller model driving the link clock, chip select and reset pin
`timescale 1ns/1ps
module ftc_host_model (
    // Link pins toward the device
    output logic link_clk,
    output logic link_cs_n,
    output logic hw_reset_n
);
    // Idle link: clock parked low, chip select and reset released
    initial begin
        link_clk = 1'b0;
        link_cs_n = 1'b1;
        hw_reset_n = 1'b1;
    end
    // One frame of n link clock rises; the clock stands still between frames
    task automatic frame(input int n);
        // Step off the system clock edge at which the caller resumed
        #10;
        link_cs_n = 1'b0;
        #170;
        repeat (n) begin
            link_clk = 1'b1;
            #160;
            link_clk = 1'b0;
            #160;
        end
        link_cs_n = 1'b1;
        #170;
    endtask
    // Reset pin pulse, long enough to outlast the device's synchroniser
    task automatic pin_reset();
        #10;
        hw_reset_n = 1'b0;
        #810;
        hw_reset_n = 1'b1;
        #810;
    endtask
endmodule

/* ftc_config_regs_bench.sv */
// Self-checking bench for the transaction configuration register block
`timescale 1ns/1ps
module ftc_config_regs_bench;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, read_addr_start, read_addr;
    logic [31:0] pwdata, prdata, rdat;
    logic link_clk, link_cs_n, hw_reset_n, lat_start, octal_mode, lat_done, rerr;
    logic [2:0] lat_kind, drive_setting;
    logic [5:0] dummy_cycles;
    logic erase_req, erase_small, sector_blank, erase_start, erase_abort, erase_ignored;
    logic prog_begin, prog_byte, read_begin, read_byte;
    logic [8:0] prog_index;
    logic small_sectors_mapped, ecc_double_detect, deep_sleep_state;
    integer n_errors = 0, comparisons = 0, seed = 67583, n_done = 0, d0, n;
    integer m3nv, m3v, m4nv, m4v;
    logic [7:0] ex;

    ftc_host_model ftc_host_model_inst (.link_clk(link_clk), .link_cs_n(link_cs_n),
        .hw_reset_n(hw_reset_n));
    ftc_config_regs ftc_config_regs_inst (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .link_clk, .link_cs_n, .hw_reset_n, .lat_start,
        .lat_kind, .octal_mode, .dummy_cycles, .lat_done, .erase_req, .erase_small,
        .sector_blank, .erase_start, .erase_abort, .erase_ignored, .prog_begin, .prog_byte,
        .prog_index, .read_begin, .read_addr_start, .read_byte, .read_addr,
        .small_sectors_mapped, .drive_setting, .ecc_double_detect, .deep_sleep_state);

    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Count completion pulses; a level stuck high would show as extra counts
    always @(posedge clk) if (lat_done === 1'b1) n_done++;

    task automatic conclude();
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready without assuming a wait-state count
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && t < 50) begin
            @(posedge clk);
            t++;
        end
        if (t == 50) n_errors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Register write plus model update; volatile map and sleep bits are read-only
    task automatic wr(input logic [7:0] a, input integer d);
        apb(1'b1, a, d);
        case (a)
            8'h00: m3nv = d;
            8'h04: m3v = (d & 'hf7) | (m3v & 'h08);
            8'h08: m4nv = d;
            8'h0c: m4v = (d & 'hfb) | (m4v & 'h04);
            default: ;
        endcase
        repeat (2) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input integer e, input logic ee);
        apb(1'b0, a, 32'h0);
        chk_bus(rdat, e);
        chk_pin(rerr, ee);
    endtask
    task automatic reload();
        ftc_host_model_inst.pin_reset();
        m3v = m3nv;
        m4v = m4nv;
        repeat (4) @(posedge clk);
    endtask
    task automatic outs();
        chk_pin(small_sectors_mapped, !m3v[3]);
        chk_pin(drive_setting, (m4v[7:5] == 4) ? 0 : m4v[7:5]);
        chk_pin(ecc_double_detect, m4v[3]);
    endtask
    task automatic lat_go(input int k, input int o);
        @(posedge clk);
        lat_start <= 1'b1;
        lat_kind <= 3'(k);
        octal_mode <= o[0];
        @(posedge clk);
        lat_start <= 1'b0;
        @(posedge clk);
    endtask
    function automatic int lat(int k, int c, int o);
        if (k == 3) return 32;
        if (k == 4) return 8;
        if (o != 0) return 3 + c;
        if (k == 2) return (c < 2) ? 0 : c - 1;
        return (c + 1) >> 1;
    endfunction
    task automatic erase(input logic sm, input logic sb);
        @(posedge clk);
        erase_req <= 1'b1;
        erase_small <= sm;
        sector_blank <= sb;
        @(posedge clk);
        erase_req <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] nxt(logic [7:0] a, int on, int l);
        int g;
        g = 8 << l;
        if (on == 0) return a + 8'h01;
        return 8'((a & ~(g - 1)) | ((a + 1) & (g - 1)));
    endfunction

    // Watchdog: the whole sequence needs well under this many cycles
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, lat_start, lat_kind, octal_mode} = '0;
        {erase_req, erase_small, sector_blank, prog_begin, prog_byte} = '0;
        {read_begin, read_addr_start, read_byte} = '0;
        arst_n = 1'b0;
        m3nv = 0;
        m3v = 0;
        m4nv = 'ha8;
        m4v = 'ha8;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Defaults of the four config registers, then an unmapped word, then the status word
        for (int a = 0; a < 16; a += 4) rd(8'(a), (a >= 8) ? 'ha8 : 0, 1'b0);
        rd(8'h14, 0, 1'b1);
        rd(8'h10, {m4v[3], 2'b00}, 1'b0);
        outs();
        chk_pin(deep_sleep_state, 1'b0);
        // Every latency code, mode and read kind; map bit write must not stick
        for (int c = 0; c < 4; c++) begin
            wr(8'h04, (c << 6) | 'h08);
            rd(8'h04, m3v, 1'b0);
            for (int o = 0; o < 2; o++)
                for (int k = 0; k < 5; k++) begin
                    lat_go(k, o);
                    chk_pin(dummy_cycles, lat(k, c, o));
                end
        end
        // Six octal dummy cycles: no completion after five link clocks, one after six
        lat_go(0, 1);
        rd(8'h10, {m4v[3], 2'b10}, 1'b0);
        d0 = n_done;
        ftc_host_model_inst.frame(5);
        repeat (12) @(posedge clk);
        chk_pin(n_done - d0, 0);
        ftc_host_model_inst.frame(1);
        repeat (12) @(posedge clk);
        chk_pin(n_done - d0, 1);
        // Erase outcomes for both maps, blank check, sector state and small erase
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                wr(8'h00, 'h08);
                reload();
                rd(8'h04, m3v, 1'b0);
                outs();
            end
            for (int i = 0; i < 8; i++) begin
                wr(8'h04, (i >> 2) << 5);
                erase(i[0], i[1]);
                ex = (i[0] && m3v[3]) ? 1 : (i[2] && i[1]) ? 2 : 4;
                chk_pin({erase_start, erase_abort, erase_ignored}, ex);
            end
        end
        // Program buffer fill of a random 250 to 761 bytes, both sizes
        for (int pb = 0; pb < 2; pb++) begin
            wr(8'h04, pb << 4);
            n = 250 + ($random(seed) & 'h1ff);
            @(posedge clk);
            prog_begin <= 1'b1;
            @(posedge clk);
            prog_begin <= 1'b0;
            prog_byte <= 1'b1;
            repeat (n) @(posedge clk);
            prog_byte <= 1'b0;
            @(posedge clk);
            chk_pin(prog_index, n % (pb ? 512 : 256));
        end
        // Wrapped reads for each length, then sequential; random start address
        for (int l = 0; l < 5; l++) begin
            wr(8'h0c, (m4v & 'he8) | ((l < 4) ? ('h10 | l) : 0));
            @(posedge clk);
            read_begin <= 1'b1;
            read_addr_start <= 8'($random(seed));
            @(posedge clk);
            ex = read_addr_start;
            read_begin <= 1'b0;
            read_byte <= 1'b1;
            repeat (70) begin
                @(posedge clk);
                chk_pin(read_addr, ex);
                ex = nxt(ex, m4v[4], m4v[1:0]);
            end
            read_byte <= 1'b0;
        end
        // Every drive code, ECC mode toggled alongside; wrap enable, sleep and wrap length bits written zero
        for (int dv = 0; dv < 8; dv++) begin
            wr(8'h0c, (dv << 5) | ((dv & 1) << 3));
            outs();
            // Host erases before trusting data stored under the other ECC mode
            erase(1'b0, 1'b0);
            chk_pin({erase_start, erase_abort, erase_ignored}, 9'h4);
        end
        rd(8'h0c, m4v, 1'b0);
        // Sleep bit reaches the volatile copy on reset; the device stays in standby, out of deep power-down, across a select pulse
        wr(8'h08, 'hac);
        reload();
        rd(8'h0c, m4v, 1'b0);
        ftc_host_model_inst.frame(1);
        repeat (8) @(posedge clk);
        chk_pin(deep_sleep_state, 1'b0);
        conclude();
    end
endmodule
